// file: verilog/smc_mode_ctrl.sv
// Operating-mode controller: power-up, reset, start-up, normal, standby and sleep sequencing.
`timescale 1ns/1ps
module smc_mode_ctrl import smc_pkg::*; #(
  parameter int POWERUP_CYCLES = us_to_cycles(POWERUP_TIMEOUT_US),
  parameter int RESET_CYCLES = us_to_cycles(RESET_PULSE_TIME_US),
  parameter int CLAMP_CYCLES = us_to_cycles(CLAMP_DETECT_TIME_US)
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RESET,
  input wire logic I_MID_POR_OK,
  input wire logic I_MID_UV,
  input wire logic I_SUPPLY_ABOVE_RESET,
  input wire logic I_SUPPLY_ABOVE_FAIL,
  input wire logic I_SUPPLY_ABOVE_HIGHEST_RESET,
  input wire logic I_THERMAL_SHUTDOWN,
  input wire logic I_MCU_RESET_LINE_N_IN,
  input wire logic I_DEV_CFG_PIN,
  input wire logic I_CFG_PIN,
  input wire logic I_FAST_FSO,
  input wire logic I_LOCAL_WAKE,
  input wire logic I_BUS_WAKE,
  input wire logic I_TIMER_WAKE,
  input wire logic I_WD_MISSED,
  input wire logic I_SPI_WRITE,
  input wire logic I_SPI_WRITE_IS_MODE,
  input wire logic [2:0] I_SPI_MODE_REQ,
  input wire logic I_WD_SERVICE_OK,
  input wire logic I_WD_ON_REQ,
  input wire logic I_CYCLIC_WAKE_EN,
  input wire logic I_CAN_WAKE_EN,
  input wire logic I_LIN_WAKE_EN,
  input wire logic I_IRQ_PENDING,
  output logic O_MAIN_SUPPLY_OUTPUT_EN,
  output logic O_AUX_REGULATOR_OUTPUT_EN,
  input wire logic I_AUX_REQ,
  output logic O_BUS_PASSIVE,
  output logic O_CAN_TX_ALLOWED,
  output logic O_FORCE_TRANSCEIVER_NORMAL,
  output logic O_WAKE_DETECT_EN,
  output logic O_FORCE_ALL_WAKEUPS,
  output logic O_SPI_EN,
  output logic O_SPI_WRITE_ACCEPT,
  output logic O_MCU_RESET_LINE_N_OUT,
  output logic O_MCU_RESET_LINE_N_OE,
  output logic O_SUPPLY_UNDERVOLTAGE_OUT_N,
  output logic O_RECEIVE_DATA_FORCE_HIGH,
  output logic O_INTERRUPT_REQUEST_N,
  output logic [1:0] O_WD_MODE,
  output logic O_FAILSAFE_OUTPUTS,
  output logic O_FAILURE_LATCHED_FLAG,
  output logic O_CLAMP_LOW_FLAG,
  output logic [2:0] O_RESET_CAUSE,
  output logic [3:0] O_MODE
);

  // ---------------------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------------------

  localparam int NSYNC = 14;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync_in;
  logic por_ok, mid_uv, above_res, above_fail, above_high, tsd, rst_line;
  logic dev_pin, cfg_pin, wu, bw, tw, wd_missed, fast_fso;

  // Comparators and pins are asynchronous to the core clock.
  assign async_in = {I_MID_POR_OK, I_MID_UV, I_SUPPLY_ABOVE_RESET, I_SUPPLY_ABOVE_FAIL,
                     I_SUPPLY_ABOVE_HIGHEST_RESET, I_THERMAL_SHUTDOWN, I_MCU_RESET_LINE_N_IN,
                     I_DEV_CFG_PIN, I_CFG_PIN, I_LOCAL_WAKE, I_BUS_WAKE, I_TIMER_WAKE,
                     I_WD_MISSED, I_FAST_FSO};

  smc_sync #(.WIDTH(NSYNC)) u_sync (
    .i_clk(I_CORE_CLK),
    .i_reset(I_RESET),
    .i_async(async_in),
    .o_sync(sync_in)
  );

  assign {por_ok, mid_uv, above_res, above_fail, above_high, tsd, rst_line,
          dev_pin, cfg_pin, wu, bw, tw, wd_missed, fast_fso} = sync_in;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------

  smc_mode_t mode_q;
  smc_mode_t mode_d;
  logic [31:0] timer_q;
  logic dev_q;
  logic [1:0] cfg_q;
  logic fsi_q;
  logic clamp_q;
  logic aux_q;
  logic wd_miss_seen_q;
  logic [2:0] cause_q;
  logic [2:0] cause_d;
  logic rst_ext_low;
  logic any_wake;
  logic nothing_enabled;
  logic failsafe_by_clamp;
  logic extreset_startup;
  logic [1:0] wd_mode_d;

  // Device is itself driving the line low only in reset-like modes.
  assign rst_ext_low = ~rst_line && (mode_q == SMC_STARTUP || mode_q == SMC_NORMAL ||
                                     mode_q == SMC_STANDBY || mode_q == SMC_FLASH);
  assign any_wake = wu | bw;
  assign nothing_enabled = ~I_WD_ON_REQ & ~I_CYCLIC_WAKE_EN & ~I_CAN_WAKE_EN & ~I_LIN_WAKE_EN;
  assign failsafe_by_clamp = ~dev_q && (cfg_q == CFG_2 || cfg_q == CFG_4);
  assign extreset_startup = rst_ext_low && mode_q == SMC_STARTUP && ~dev_q;

  function automatic logic supply_active(input smc_mode_t m);
    return m == SMC_NORMAL || m == SMC_STANDBY || m == SMC_RESET ||
           m == SMC_STARTUP || m == SMC_FLASH;
  endfunction

  // ---------------------------------------------------------------------------
  // Next-mode decision
  // ---------------------------------------------------------------------------

  // Evaluated once per clock; priority runs shut-down, undervoltage, then requests.
  always_comb begin
    mode_d = mode_q;
    cause_d = cause_q;
    if (!por_ok) begin
      mode_d = SMC_SHUTDOWN;
    end else if (supply_active(mode_q) && !above_res) begin
      mode_d = SMC_POWERUP;
    end else begin
      case (mode_q)
        SMC_SHUTDOWN: begin
          mode_d = SMC_CONFIG;
        end
        SMC_CONFIG: begin
          mode_d = SMC_POWERUP;
        end
        SMC_POWERUP: begin
          if (above_res) begin
            mode_d = SMC_RESET;
            cause_d = CAUSE_POWERUP;
          end else if (tsd) begin
            mode_d = SMC_FAILSAFE;
          end else if (timer_q >= 32'(POWERUP_CYCLES) && !above_fail) begin
            mode_d = SMC_FAILSAFE;
          end
        end
        SMC_RESET: begin
          if (timer_q >= 32'(RESET_CYCLES) && rst_line) begin
            mode_d = SMC_STARTUP;
          end else if (clamp_q && failsafe_by_clamp) begin
            mode_d = SMC_FAILSAFE;
          end
        end
        SMC_STARTUP: begin
          if (rst_ext_low) begin
            mode_d = SMC_RESET;
            cause_d = CAUSE_EXTERNAL;
          end else if (I_SPI_WRITE && I_SPI_WRITE_IS_MODE && I_WD_SERVICE_OK) begin
            if (I_SPI_MODE_REQ == REQ_NORMAL) begin
              mode_d = SMC_NORMAL;
            end else if (I_SPI_MODE_REQ == REQ_FLASH) begin
              mode_d = dev_q ? SMC_FLASH : SMC_RESET;
              cause_d = dev_q ? cause_q : CAUSE_FLASH_ENTRY;
            end else if (I_SPI_MODE_REQ == REQ_CONFIG) begin
              mode_d = SMC_CONFIG;
            end else if (!dev_q) begin
              mode_d = SMC_RESET;
              cause_d = CAUSE_BAD_MODE;
            end
          end else if (wd_missed && !dev_q) begin
            // Development configuration keeps start-up on a missed service.
            mode_d = (cfg_q == CFG_2 || cfg_q == CFG_4) ? SMC_FAILSAFE : SMC_RESET;
            cause_d = CAUSE_WATCHDOG;
          end
        end
        SMC_NORMAL, SMC_STANDBY, SMC_FLASH: begin
          if (rst_ext_low) begin
            mode_d = SMC_RESET;
            cause_d = CAUSE_EXTERNAL;
          end else if (I_SPI_WRITE && I_SPI_WRITE_IS_MODE) begin
            case (I_SPI_MODE_REQ)
              REQ_NORMAL: mode_d = (mode_q == SMC_FLASH) ? mode_q : SMC_NORMAL;
              REQ_STANDBY: mode_d = (mode_q == SMC_NORMAL) ? SMC_STANDBY : mode_q;
              REQ_SLEEP: mode_d = (mode_q == SMC_NORMAL) ? SMC_SLEEP : mode_q;
              REQ_CONFIG: mode_d = (mode_q == SMC_NORMAL) ? SMC_CONFIG : mode_q;
              REQ_FAILSAFE: mode_d = dev_q ? SMC_FAILSAFE : SMC_RESET;
              default: mode_d = SMC_RESET;
            endcase
            if (mode_d == SMC_RESET) begin
              case (I_SPI_MODE_REQ)
                REQ_RESET: cause_d = CAUSE_SPI_RESET;
                REQ_FLASH: cause_d = CAUSE_FLASH_ENTRY;
                REQ_FLASH_EXIT: cause_d = CAUSE_FLASH_EXIT;
                default: cause_d = CAUSE_BAD_MODE;
              endcase
            end
          end else if (wd_missed && !dev_q) begin
            mode_d = (cfg_q == CFG_2 || cfg_q == CFG_4) ? SMC_FAILSAFE : SMC_RESET;
            cause_d = CAUSE_WATCHDOG;
          end
        end
        SMC_SLEEP: begin
          if (any_wake) begin
            mode_d = SMC_POWERUP;
          end else if (mid_uv) begin
            mode_d = SMC_SHUTDOWN;
          end
        end
        SMC_FAILSAFE: begin
          if (tsd) begin
            mode_d = SMC_FAILSAFE;
          end else if (any_wake) begin
            mode_d = SMC_POWERUP;
          end
        end
        default: mode_d = SMC_SHUTDOWN;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Mode, timer and cause registers
  // ---------------------------------------------------------------------------

  // The timer restarts on every mode change, so each mode times itself.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      mode_q <= SMC_SHUTDOWN;
      timer_q <= 32'h0;
      cause_q <= CAUSE_NONE;
    end else begin
      mode_q <= mode_d;
      cause_q <= cause_d;
      if (mode_d != mode_q) begin
        timer_q <= 32'h0;
      end else if (timer_q != 32'hffffffff) begin
        timer_q <= timer_q + 32'h1;
      end
    end
  end

  // Configuration is latched only in configuration mode and held afterwards.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      dev_q <= 1'b0;
      cfg_q <= CFG_1;
    end else if (mode_q == SMC_CONFIG) begin
      dev_q <= dev_pin;
      cfg_q <= {~fast_fso, ~cfg_pin};
    end
  end

  // Clamp flag and failure latch; a new event wins over clearing, which is on start-up for the clamp and a serviced write in normal for the latch.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      clamp_q <= 1'b0;
      fsi_q <= 1'b0;
      wd_miss_seen_q <= 1'b0;
    end else begin
      if (mode_q == SMC_RESET && !rst_line && timer_q >= 32'(CLAMP_CYCLES)) begin
        clamp_q <= 1'b1;
      end else if (mode_q == SMC_STARTUP) begin
        clamp_q <= 1'b0;
      end
      if (wd_missed && !dev_q && supply_active(mode_q) && mode_q != SMC_RESET) begin
        wd_miss_seen_q <= 1'b1;
      end
      // Config 1 fails on first miss; config 3 needs a second one.
      if (extreset_startup) begin
        fsi_q <= 1'b1;
      end else if (mode_q == SMC_RESET && clamp_q && !dev_q) begin
        fsi_q <= 1'b1;
      end else if (wd_missed && !dev_q && supply_active(mode_q) &&
                   (cfg_q == CFG_1 || cfg_q == CFG_2 || wd_miss_seen_q)) begin
        fsi_q <= 1'b1;
      end else if (mode_q == SMC_FAILSAFE) begin
        fsi_q <= 1'b1;
      end else if (mode_q == SMC_NORMAL && I_SPI_WRITE && I_SPI_WRITE_IS_MODE && I_WD_SERVICE_OK) begin
        fsi_q <= 1'b0;
      end
    end
  end

  // Auxiliary regulator holds its state in power-up and reset, follows its request in start-up, normal, standby and flash, and clears elsewhere.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      aux_q <= 1'b0;
    end else if (mode_q == SMC_SLEEP || mode_q == SMC_SHUTDOWN || mode_q == SMC_CONFIG ||
                 mode_q == SMC_FAILSAFE) begin
      aux_q <= 1'b0;
    end else if (mode_q == SMC_STARTUP || mode_q == SMC_NORMAL || mode_q == SMC_STANDBY ||
                 mode_q == SMC_FLASH) begin
      aux_q <= I_AUX_REQ;
    end
  end

  // ---------------------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------------------

  always_comb begin
    case (mode_d)
      SMC_STARTUP, SMC_FLASH: wd_mode_d = 2'h1;
      SMC_NORMAL: wd_mode_d = 2'h2;
      SMC_STANDBY: wd_mode_d = I_WD_ON_REQ ? 2'h1 : 2'h0;
      default: wd_mode_d = 2'h0;
    endcase
  end

  // Mode-dependent outputs follow the next mode so that they change with the mode itself; the flags follow their registers.
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      O_MAIN_SUPPLY_OUTPUT_EN <= 1'b0;
      O_AUX_REGULATOR_OUTPUT_EN <= 1'b0;
      O_BUS_PASSIVE <= 1'b1;
      O_CAN_TX_ALLOWED <= 1'b0;
      O_FORCE_TRANSCEIVER_NORMAL <= 1'b0;
      O_WAKE_DETECT_EN <= 1'b0;
      O_FORCE_ALL_WAKEUPS <= 1'b0;
      O_SPI_EN <= 1'b0;
      O_SPI_WRITE_ACCEPT <= 1'b0;
      O_MCU_RESET_LINE_N_OUT <= 1'b0;
      O_MCU_RESET_LINE_N_OE <= 1'b1;
      O_SUPPLY_UNDERVOLTAGE_OUT_N <= 1'b0;
      O_RECEIVE_DATA_FORCE_HIGH <= 1'b1;
      O_INTERRUPT_REQUEST_N <= 1'b1;
      O_WD_MODE <= 2'h0;
      O_FAILSAFE_OUTPUTS <= 1'b0;
      O_FAILURE_LATCHED_FLAG <= 1'b0;
      O_CLAMP_LOW_FLAG <= 1'b0;
      O_RESET_CAUSE <= CAUSE_NONE;
      O_MODE <= 4'h0;
    end else begin
      O_MAIN_SUPPLY_OUTPUT_EN <= supply_active(mode_d) || mode_d == SMC_POWERUP;
      O_AUX_REGULATOR_OUTPUT_EN <= aux_q && mode_d != SMC_SLEEP && mode_d != SMC_FAILSAFE;
      O_BUS_PASSIVE <= !(mode_d == SMC_STARTUP || mode_d == SMC_NORMAL ||
                         mode_d == SMC_STANDBY || mode_d == SMC_FLASH);
      O_CAN_TX_ALLOWED <= mode_d == SMC_NORMAL || mode_d == SMC_FLASH ||
                          (mode_d == SMC_STARTUP && dev_q);
      O_FORCE_TRANSCEIVER_NORMAL <= dev_q && (mode_d == SMC_STARTUP || mode_d == SMC_FLASH);
      O_WAKE_DETECT_EN <= !(mode_d == SMC_POWERUP || mode_d == SMC_RESET ||
                            mode_d == SMC_CONFIG || mode_d == SMC_SHUTDOWN);
      O_FORCE_ALL_WAKEUPS <= ((mode_d == SMC_STANDBY) && nothing_enabled) ||
                             ((mode_d == SMC_SLEEP) && !I_CAN_WAKE_EN && !I_LIN_WAKE_EN) ||
                             mode_d == SMC_FAILSAFE;
      O_SPI_EN <= mode_d == SMC_STARTUP || mode_d == SMC_NORMAL ||
                  mode_d == SMC_STANDBY || mode_d == SMC_FLASH;
      O_SPI_WRITE_ACCEPT <= !(mode_d == SMC_STARTUP && fsi_q && !I_SPI_WRITE_IS_MODE) &&
                            (mode_d == SMC_STARTUP || mode_d == SMC_NORMAL ||
                             mode_d == SMC_STANDBY || mode_d == SMC_FLASH);
      // Open drain: drive low only when asserting reset, otherwise release.
      O_MCU_RESET_LINE_N_OUT <= 1'b0;
      O_MCU_RESET_LINE_N_OE <= !(mode_d == SMC_STARTUP || mode_d == SMC_NORMAL ||
                                 mode_d == SMC_STANDBY || mode_d == SMC_FLASH ||
                                 (mode_d == SMC_RESET && timer_q >= 32'(RESET_CYCLES)));
      O_SUPPLY_UNDERVOLTAGE_OUT_N <= supply_active(mode_d) && above_high;
      O_RECEIVE_DATA_FORCE_HIGH <= !(mode_d == SMC_STARTUP || mode_d == SMC_NORMAL ||
                                     mode_d == SMC_STANDBY || mode_d == SMC_FLASH);
      O_INTERRUPT_REQUEST_N <= !((mode_d == SMC_NORMAL || mode_d == SMC_FLASH || mode_d == SMC_STARTUP) &&
                                 I_IRQ_PENDING) &&
                               !(mode_d == SMC_STANDBY && (I_IRQ_PENDING || any_wake || tw));
      O_WD_MODE <= wd_mode_d;
      O_FAILSAFE_OUTPUTS <= fsi_q && !dev_q;
      O_FAILURE_LATCHED_FLAG <= fsi_q;
      O_CLAMP_LOW_FLAG <= clamp_q;
      O_RESET_CAUSE <= cause_d;
      O_MODE <= 4'(mode_d);
    end
  end

  initial begin
    if (RESET_CYCLES < 1 || POWERUP_CYCLES < 1 || CLAMP_CYCLES <= RESET_CYCLES) begin
      $error("smc_mode_ctrl timing parameters out of range");
    end
  end

endmodule

// file: verilog/smc_pkg.sv
// Package with mode encodings, configuration codes, reset-cause codes and timing constants.
package smc_pkg;

  // ---------------------------------------------------------------------------
  // Operating modes
  // ---------------------------------------------------------------------------
  typedef enum logic [3:0] {
    SMC_CONFIG,
    SMC_POWERUP,
    SMC_RESET,
    SMC_STARTUP,
    SMC_NORMAL,
    SMC_STANDBY,
    SMC_SLEEP,
    SMC_FLASH,
    SMC_FAILSAFE,
    SMC_SHUTDOWN
  } smc_mode_t;

  // ---------------------------------------------------------------------------
  // Mode request codes carried by a watchdog service or mode command
  // ---------------------------------------------------------------------------
  localparam logic [2:0] REQ_NORMAL = 3'h0;
  localparam logic [2:0] REQ_STANDBY = 3'h1;
  localparam logic [2:0] REQ_SLEEP = 3'h2;
  localparam logic [2:0] REQ_FLASH = 3'h3;
  localparam logic [2:0] REQ_RESET = 3'h4;
  localparam logic [2:0] REQ_CONFIG = 3'h5;
  localparam logic [2:0] REQ_FAILSAFE = 3'h6;
  localparam logic [2:0] REQ_FLASH_EXIT = 3'h7;

  // ---------------------------------------------------------------------------
  // Reset cause codes
  // ---------------------------------------------------------------------------
  localparam logic [2:0] CAUSE_NONE = 3'h0;
  localparam logic [2:0] CAUSE_POWERUP = 3'h1;
  localparam logic [2:0] CAUSE_EXTERNAL = 3'h2;
  localparam logic [2:0] CAUSE_FLASH_ENTRY = 3'h3;
  localparam logic [2:0] CAUSE_FLASH_EXIT = 3'h4;
  localparam logic [2:0] CAUSE_SPI_RESET = 3'h5;
  localparam logic [2:0] CAUSE_BAD_MODE = 3'h6;
  localparam logic [2:0] CAUSE_WATCHDOG = 3'h7;

  // ---------------------------------------------------------------------------
  // Configuration codes: {fail-safe only on second failure, fail-safe entry}
  // ---------------------------------------------------------------------------
  localparam logic [1:0] CFG_1 = 2'h0;
  localparam logic [1:0] CFG_2 = 2'h1;
  localparam logic [1:0] CFG_3 = 2'h2;
  localparam logic [1:0] CFG_4 = 2'h3;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_HZ = 40000000;
  localparam int POWERUP_TIMEOUT_US = 10000;
  localparam int RESET_PULSE_TIME_US = 2000;
  localparam int CLAMP_DETECT_TIME_US = 8000;
  localparam int SYNC_RESET_VALUE = 0;
  localparam logic [1:0] SYNC_INIT = 2'h0;

  // Least times round up to whole cycles.
  function automatic int us_to_cycles(input int us);
    longint prod;
    prod = longint'(us) * longint'(CLK_HZ);
    return int'((prod + 64'd999999) / 64'd1000000);
  endfunction

endpackage

// file: verilog/smc_sync.sv
// Two-flip-flop synchroniser for a vector of asynchronous levels.
`timescale 1ns/1ps
module smc_sync import smc_pkg::*; #(
  parameter int WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;

  // -------------------------------------------------------------------------
  // Capture stages
  // -------------------------------------------------------------------------

  // The first stage is read only by the second to contain metastability.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

  initial begin
    if (WIDTH < 1) begin
      $error("smc_sync needs WIDTH of at least one");
    end
  end

endmodule

// file: bench/smc_mode_ctrl_sva.sv
// Checker for the mode controller outputs.
`timescale 1ns/1ps
module smc_mode_ctrl_chk (
  input wire logic I_CORE_CLK,
  input wire logic I_RESET,
  input wire logic [3:0] O_MODE,
  input wire logic O_SPI_EN,
  input wire logic [1:0] O_WD_MODE,
  input wire logic O_MCU_RESET_LINE_N_OE,
  input wire logic O_MAIN_SUPPLY_OUTPUT_EN,
  input wire logic O_BUS_PASSIVE,
  input wire logic O_CAN_TX_ALLOWED
);
  // One clock domain, so clock and reset are given once.
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RESET);
  AST_PWRUP: assert property (
    O_MODE == 4'h1 |-> O_MAIN_SUPPLY_OUTPUT_EN && O_MCU_RESET_LINE_N_OE && !O_SPI_EN) else $error("powerup");
  AST_PWRUP_EXIT: assert property (
    $past(O_MODE) == 4'h1 && O_MODE != 4'h1 |-> O_MODE inside {4'h2, 4'h8, 4'h9}) else $error("pwr exit");
  AST_RST: assert property (
    O_MODE == 4'h2 |-> O_MAIN_SUPPLY_OUTPUT_EN && O_BUS_PASSIVE && !O_SPI_EN) else $error("reset");
  AST_START: assert property (
    O_MODE == 4'h3 |-> O_SPI_EN && O_WD_MODE == 2'h1) else $error("startup");
  AST_NORM: assert property (
    O_MODE == 4'h4 |-> O_WD_MODE == 2'h2 && !O_MCU_RESET_LINE_N_OE) else $error("normal");
  AST_STBY_IN: assert property (
    $rose(O_MODE == 4'h5) |-> $past(O_MODE) == 4'h4) else $error("standby entry");
  AST_STBY_CAN: assert property (
    O_MODE == 4'h5 |-> !O_CAN_TX_ALLOWED && O_SPI_EN) else $error("standby");
  AST_SLEEP: assert property (
    O_MODE == 4'h6 |-> !O_MAIN_SUPPLY_OUTPUT_EN && !O_SPI_EN && O_MCU_RESET_LINE_N_OE) else $error("sleep");
  AST_SLEEP_IN: assert property (
    $rose(O_MODE == 4'h6) |-> $past(O_MODE) == 4'h4) else $error("sleep entry");
  // Main scenarios reached.
  cover property (O_MODE == 4'h4);
  cover property (O_MODE == 4'h5);
  cover property (O_MODE == 4'h6);
endmodule
bind smc_mode_ctrl smc_mode_ctrl_chk i_smc_mode_ctrl_chk (.*);

// file: bench/smc_mcu_model.sv
// Microcontroller side of the open-drain reset line.
`timescale 1ns/1ps
module smc_mcu_model (
  input wire logic i_oe,
  input wire logic i_hold,
  output logic o_line
);
  // Pull-up wins when nobody pulls low; the bench holds only after a good service.
  assign o_line = !(i_oe || i_hold);
endmodule

// file: bench/smc_mode_ctrl_test.sv
// Self-checking testbench for the operating-mode controller.
`timescale 1ns/1ps
module smc_mode_ctrl_test import smc_pkg::*;;
  logic I_CORE_CLK = 0, I_RESET = 1, I_MID_POR_OK = 1, I_MID_UV = 0, I_THERMAL_SHUTDOWN = 0, I_DEV_CFG_PIN = 0;
  logic I_SUPPLY_ABOVE_RESET = 0, I_SUPPLY_ABOVE_FAIL = 0, I_SUPPLY_ABOVE_HIGHEST_RESET = 0, I_CFG_PIN = 1;
  logic I_FAST_FSO = 1, I_LOCAL_WAKE = 0, I_BUS_WAKE = 0, I_TIMER_WAKE = 0, I_WD_MISSED = 0, I_SPI_WRITE = 0;
  logic I_SPI_WRITE_IS_MODE = 0, I_WD_SERVICE_OK = 0, I_WD_ON_REQ = 0, I_CYCLIC_WAKE_EN = 0, I_CAN_WAKE_EN = 0;
  logic I_LIN_WAKE_EN = 0, I_IRQ_PENDING = 0, I_AUX_REQ = 0, I_MCU_RESET_LINE_N_IN, hold = 0;
  logic [2:0] I_SPI_MODE_REQ = 3'h0;
  logic O_MAIN_SUPPLY_OUTPUT_EN, O_AUX_REGULATOR_OUTPUT_EN, O_BUS_PASSIVE, O_CAN_TX_ALLOWED, O_WAKE_DETECT_EN;
  logic O_FORCE_TRANSCEIVER_NORMAL, O_FORCE_ALL_WAKEUPS, O_SPI_EN, O_SPI_WRITE_ACCEPT, O_MCU_RESET_LINE_N_OUT;
  logic O_MCU_RESET_LINE_N_OE, O_SUPPLY_UNDERVOLTAGE_OUT_N, O_RECEIVE_DATA_FORCE_HIGH, O_INTERRUPT_REQUEST_N;
  logic O_FAILSAFE_OUTPUTS, O_FAILURE_LATCHED_FLAG, O_CLAMP_LOW_FLAG;
  logic [1:0] O_WD_MODE;
  logic [2:0] O_RESET_CAUSE;
  logic [3:0] O_MODE;
  int err_total = 0, checks = 0, seed = 32'h011c, pulse = 0;
  smc_mode_ctrl #(.POWERUP_CYCLES(20), .RESET_CYCLES(8), .CLAMP_CYCLES(40)) i_smc_mode_ctrl (.*);
  smc_mcu_model i_smc_mcu_model (.i_oe(O_MCU_RESET_LINE_N_OE), .i_hold(hold), .o_line(I_MCU_RESET_LINE_N_IN));
  // Core clock at 40 MHz.
  always #12.5 I_CORE_CLK = ~I_CORE_CLK;
  // Random side inputs keep that logic busy; the counter measures the reset pulse.
  always @(negedge I_CORE_CLK) begin
    I_IRQ_PENDING <= 1'($random(seed));
    I_AUX_REQ <= 1'($random(seed));
    if (O_MODE === 4'h2 && O_MCU_RESET_LINE_N_OE === 1'b1) pulse++;
  end
  // Reference model of request handling, kept in plain integers.
  function automatic int nxt(int cur, int req);
    if (cur == 5 && req == 0) return 4;
    if (cur != 4 && (req == 1 || req == 2)) return cur;
    if (req < 3) return 4 + req;
    return 2;
  endfunction
  // Compares and counts; an unknown never matches.
  task automatic chk(input logic [3:0] s, input logic [3:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Bounded wait for a mode; the first cycles let a refused request show that it changed nothing.
  task automatic wait_m(input logic [3:0] e);
    repeat (3) @(negedge I_CORE_CLK);
    for (int k = 0; k < 200 && O_MODE !== e; k++) @(negedge I_CORE_CLK);
    chk(O_MODE, e);
    if (O_MODE !== e) test_done();
  endtask
  // One mode-control write frame, a single-cycle pulse.
  task automatic go(input logic [2:0] r);
    logic [3:0] e;
    e = 4'(nxt(int'(O_MODE), int'(r)));
    I_SPI_MODE_REQ = r;
    I_SPI_WRITE_IS_MODE = 1;
    I_WD_SERVICE_OK = 1;
    I_SPI_WRITE = 1;
    @(negedge I_CORE_CLK);
    I_SPI_WRITE = 0;
    wait_m(e);
  endtask
  // Main sequence.
  initial begin
    repeat (4) @(negedge I_CORE_CLK);
    I_RESET = 0;
    wait_m(4'h1);
    chk(O_SUPPLY_UNDERVOLTAGE_OUT_N, 0);
    chk(O_RECEIVE_DATA_FORCE_HIGH, 1);
    chk(O_WAKE_DETECT_EN, 0);
    I_SUPPLY_ABOVE_FAIL = 1;
    I_SUPPLY_ABOVE_RESET = 1;
    I_SUPPLY_ABOVE_HIGHEST_RESET = 1;
    wait_m(4'h2);
    chk(O_RESET_CAUSE, CAUSE_POWERUP);
    chk(O_SUPPLY_UNDERVOLTAGE_OUT_N, 1);
    chk(O_SPI_EN, 0);
    wait_m(4'h3);
    chk(pulse inside {8, 9}, 1);
    chk(O_SPI_EN, 1);
    go(REQ_NORMAL);
    chk(O_INTERRUPT_REQUEST_N, !I_IRQ_PENDING);
    chk(O_SUPPLY_UNDERVOLTAGE_OUT_N, 1);
    go(REQ_STANDBY);
    chk(O_FORCE_ALL_WAKEUPS, 1);
    go(REQ_SLEEP);
    go(REQ_NORMAL);
    I_CAN_WAKE_EN = 1'($random(seed));
    repeat (4) @(negedge I_CORE_CLK);
    go(REQ_SLEEP);
    chk(O_FORCE_ALL_WAKEUPS, !I_CAN_WAKE_EN);
    if (seed[0]) I_LOCAL_WAKE = 1;
    else I_BUS_WAKE = 1;
    wait_m(4'h1);
    I_LOCAL_WAKE = 0;
    I_BUS_WAKE = 0;
    wait_m(4'h3);
    go(REQ_NORMAL);
    go(REQ_RESET);
    chk(O_RESET_CAUSE, CAUSE_SPI_RESET);
    wait_m(4'h3);
    go(REQ_NORMAL);
    go(REQ_FAILSAFE);
    chk(O_RESET_CAUSE, CAUSE_BAD_MODE);
    wait_m(4'h3);
    go(REQ_NORMAL);
    hold = 1;
    wait_m(4'h2);
    repeat (60) @(negedge I_CORE_CLK);
    chk(O_MODE, 4'h2);
    chk(O_CLAMP_LOW_FLAG, 1);
    chk(O_RESET_CAUSE, CAUSE_EXTERNAL);
    chk(O_FAILURE_LATCHED_FLAG, 1);
    chk(O_FAILSAFE_OUTPUTS, 1);
    hold = 0;
    wait_m(4'h3);
    I_SPI_WRITE_IS_MODE = 0;
    @(negedge I_CORE_CLK);
    chk(O_SPI_WRITE_ACCEPT, 0);
    I_SPI_WRITE_IS_MODE = 1;
    @(negedge I_CORE_CLK);
    chk(O_SPI_WRITE_ACCEPT, 1);
    go(REQ_NORMAL);
    I_SUPPLY_ABOVE_RESET = 0;
    wait_m(4'h1);
    test_done();
  end
endmodule
